// file: verilog/mono_pack_pkg.sv
// Package for the monochrome pixel packer: format codes, field layout, limits.
// Assumes a single pixel clock domain; shared by the packer, its checker and its testbench.
package mono_pack_pkg;

    // =========================================================================
    // Formats
    typedef enum logic [1:0] {
        FMT_BYTE8 = 2'b00,
        FMT_WORD16 = 2'b01,
        FMT_PACK12 = 2'b10,
        FMT_NONE = 2'b11
    } pix_fmt_t;

    // Identifier reported in the frame leader
    typedef enum logic [1:0] {
        LID_MONO8 = 2'b00,
        LID_MONO12 = 2'b01,
        LID_MONO12_PACKED = 2'b10,
        LID_MONO16 = 2'b11
    } leader_id_t;

    // =========================================================================
    // Widths and fields
    localparam int PIX_W = 12;
    localparam int BYTE_W = 8;
    localparam int HI_MSB = 11;
    localparam int HI_LSB = 4;
    localparam int LO_MSB = 3;
    localparam int LO_LSB = 0;
    localparam int FIFO_DEPTH = 16;
    localparam logic [PIX_W-1:0] PIX_MAX = 12'hFFF;
    localparam logic [3:0] PAD_ZERO = 4'h0;
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

endpackage

// file: verilog/pack_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module pack_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    wire push;
    wire pop;

    // =========================================================================
    // Handshakes
    assign in_ready = (cnt_ff != (AW+1)'(DEPTH)); // Refuse only when all DEPTH words are held
    assign out_valid = (cnt_ff != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ff];

    // Storage
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ff] <= in_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge mclk) begin
        if (srst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= rd_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // pack_fifo

// file: verilog/mono_pixel_packer.sv
// Mono pixel packer: turns 12-bit brightness samples into an ordered byte stream.
// Assumes pixels arrive synchronous to mclk with valid/ready, and that the
// transport downstream drains bytes with valid/ready and may stall.
`timescale 1ns/10ps
module mono_pixel_packer
    import mono_pack_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire mono_pack_pkg::pix_fmt_t fmt_sel,
    input wire logic frame_start,
    input wire logic [mono_pack_pkg::PIX_W-1:0] pix_data,
    input wire logic pix_valid,
    input wire logic pix_last,
    output logic pix_ready,
    output logic [mono_pack_pkg::BYTE_W-1:0] byte_data,
    output logic byte_valid,
    output logic byte_last,
    input wire logic byte_ready,
    output mono_pack_pkg::leader_id_t leader_id,
    output logic fmt_err
);
    import mono_pack_pkg::*;

    // Pack step states
    typedef enum logic [1:0] {
        ST_A = 2'b00,
        ST_B = 2'b01,
        ST_C = 2'b10,
        ST_D = 2'b11 // Lone final pixel: nibble byte pending
    } step_t;

    pix_fmt_t fmt_ff;
    step_t step_ff;
    step_t nxt_step;
    logic [PIX_W-1:0] even_ff;
    logic [PIX_W-1:0] odd_ff;
    logic last_ff;
    logic [PIX_W-1:0] nxt_even;
    logic [PIX_W-1:0] nxt_odd;
    logic nxt_last;
    logic err_ff;
    logic [BYTE_W:0] fifo_in;
    logic [BYTE_W:0] fifo_out;
    logic push_byte;
    logic fifo_ready;
    logic [BYTE_W-1:0] emit_byte;
    logic emit_last;
    wire fmt_ok;

    // Format is supported only if it is one of the three mono layouts
    function automatic logic fmt_supported(input pix_fmt_t f);
        fmt_supported = (f == FMT_BYTE8) || (f == FMT_WORD16) || (f == FMT_PACK12);
    endfunction

    // =========================================================================
    // Frame format latch
    assign fmt_ok = fmt_supported(fmt_sel);

    // Format follows the selection only at frame start, and only if supported
    always_ff @(posedge mclk) begin
        if (srst) begin
            fmt_ff <= FMT_BYTE8;
            err_ff <= 1'b0;
        end else if (frame_start && step_ff == ST_A) begin
            if (fmt_ok) begin
                fmt_ff <= fmt_sel;
            end
            err_ff <= !fmt_ok;
        end
    end
    assign fmt_err = err_ff;

    // Leader identifier: sixteen-bit container reports the unpacked twelve-bit id
    assign leader_id = (fmt_ff == FMT_WORD16) ? LID_MONO12 :
                       (fmt_ff == FMT_PACK12) ? LID_MONO12_PACKED : LID_MONO8;

    // =========================================================================
    // Byte selection per format and step
    always_comb begin
        emit_byte = BYTE_RST;
        emit_last = 1'b0;
        push_byte = 1'b0;
        nxt_step = step_ff;
        nxt_even = even_ff;
        nxt_odd = odd_ff;
        nxt_last = last_ff;
        case (fmt_ff)
            FMT_WORD16: begin
                case (step_ff)
                    ST_A: begin
                        // Capture pixel, send low byte
                        if (pix_valid) begin
                            emit_byte = pix_data[BYTE_W-1:0];
                            push_byte = 1'b1;
                            if (fifo_ready) begin
                                nxt_even = pix_data;
                                nxt_last = pix_last;
                                nxt_step = ST_B;
                            end
                        end
                    end
                    ST_B: begin
                        // High byte: four pad zeros above bits 11..8
                        emit_byte = {PAD_ZERO, even_ff[HI_MSB:BYTE_W]};
                        emit_last = last_ff;
                        push_byte = 1'b1;
                        if (fifo_ready) begin
                            nxt_step = ST_A;
                        end
                    end
                    default: begin
                        nxt_step = ST_A;
                    end
                endcase
            end
            FMT_PACK12: begin
                case (step_ff)
                    ST_A: begin
                        // Even pixel: send its bits 11..4 now
                        if (pix_valid) begin
                            emit_byte = pix_data[HI_MSB:HI_LSB];
                            push_byte = 1'b1;
                            if (fifo_ready) begin
                                nxt_even = pix_data;
                                nxt_odd = '0;
                                nxt_last = pix_last;
                                nxt_step = pix_last ? ST_D : ST_B;
                            end
                        end
                    end
                    ST_B: begin
                        // Odd pixel: shared nibble byte, odd nibble on top
                        if (pix_valid) begin
                            emit_byte = {pix_data[LO_MSB:LO_LSB], even_ff[LO_MSB:LO_LSB]};
                            push_byte = 1'b1;
                            if (fifo_ready) begin
                                nxt_odd = pix_data;
                                nxt_last = pix_last;
                                nxt_step = ST_C;
                            end
                        end
                    end
                    ST_D: begin
                        // Lone final even pixel keeps its low nibble; zero odd nibble on top
                        emit_byte = {PAD_ZERO, even_ff[LO_MSB:LO_LSB]};
                        push_byte = 1'b1;
                        if (fifo_ready) begin
                            nxt_step = ST_C;
                        end
                    end
                    ST_C: begin
                        // Odd pixel bits 11..4, zero when the final pixel was alone
                        emit_byte = odd_ff[HI_MSB:HI_LSB];
                        emit_last = last_ff;
                        push_byte = 1'b1;
                        if (fifo_ready) begin
                            nxt_step = ST_A;
                        end
                    end
                    default: begin
                        nxt_step = ST_A;
                    end
                endcase
            end
            default: begin
                // Eight-bit: top byte of the twelve-bit sample, unsigned full range
                emit_byte = pix_data[HI_MSB:HI_LSB];
                emit_last = pix_last;
                push_byte = pix_valid;
                nxt_step = ST_A;
            end
        endcase
    end

    // Input is only accepted together with the byte it produces
    assign pix_ready = fifo_ready && (step_ff == ST_A || (fmt_ff == FMT_PACK12 && step_ff == ST_B));
    assign fifo_in = {emit_last, emit_byte};

    // =========================================================================
    // Step state and pixel holding registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            step_ff <= ST_A;
            even_ff <= '0;
            odd_ff <= '0;
            last_ff <= 1'b0;
        end else begin
            step_ff <= nxt_step;
            even_ff <= nxt_even;
            odd_ff <= nxt_odd;
            last_ff <= nxt_last;
        end
    end

    // =========================================================================
    // Output FIFO keeps byte order and carries backpressure back to the input
    pack_fifo #(
        .WIDTH(BYTE_W + 1),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .srst(srst),
        .in_data(fifo_in),
        .in_valid(push_byte),
        .in_ready(fifo_ready),
        .out_data(fifo_out),
        .out_valid(byte_valid),
        .out_ready(byte_ready)
    );

    assign byte_data = fifo_out[BYTE_W-1:0];
    assign byte_last = fifo_out[BYTE_W];
endmodule // mono_pixel_packer

// file: verification/mono_pixel_packer_monitor.sv
// Port checker for the mono pixel packer.
// Assumes one clock, sync reset; bound to every packer instance.
`timescale 1ns/10ps
module mono_pixel_packer_monitor
    import mono_pack_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic frame_start,
    input wire logic pix_valid,
    input wire logic pix_ready,
    input wire logic [mono_pack_pkg::BYTE_W-1:0] byte_data,
    input wire logic byte_valid,
    input wire logic byte_last,
    input wire logic byte_ready,
    input wire mono_pack_pkg::leader_id_t leader_id,
    input wire logic fmt_err
);
    // ======================================================================
    // Byte parity within a frame
    logic odd_ff;
    logic nxt_odd;
    wire pop = byte_valid && byte_ready;
    assign nxt_odd = pop ? (!odd_ff && !byte_last) : odd_ff;
    // Odd flag clears at each frame end
    always_ff @(posedge mclk) begin
        if (srst) odd_ff <= 1'b0;
        else odd_ff <= nxt_odd;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    property p_rst_idle;
        $fell(srst) |-> !byte_valid && pix_ready && leader_id == LID_MONO8 && !fmt_err;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("Not idle after reset");
    property p_hold;
        byte_valid && !byte_ready |=> byte_valid && $stable(byte_data) && $stable(byte_last);
    endproperty
    a_hold: assert property (p_hold) else $error("Byte changed under stall");
    property p_no16;
        leader_id != LID_MONO16;
    endproperty
    a_no16: assert property (p_no16) else $error("Leader shows 16-bit id");
    property p_err_cause;
        $rose(fmt_err) |-> $past(frame_start);
    endproperty
    a_err_cause: assert property (p_err_cause) else $error("Error flag without frame start");
    property p_lid_cause;
        !$stable(leader_id) |-> $past(frame_start) || $past(srst);
    endproperty
    a_lid_cause: assert property (p_lid_cause) else $error("Format changed mid frame");
    property p_push;
        pix_valid && pix_ready && leader_id != LID_MONO12_PACKED |=> byte_valid;
    endproperty
    a_push: assert property (p_push) else $error("Pixel gave no byte");
    property p_refuse16;
        leader_id == LID_MONO12 && pix_valid && pix_ready |=> !pix_ready;
    endproperty
    a_refuse16: assert property (p_refuse16) else $error("Ready during high byte");
    property p_hi_zero;
        leader_id == LID_MONO12 && pop && odd_ff |-> byte_data[7:4] == PAD_ZERO;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("High byte pad not zero");
endmodule // mono_pixel_packer_monitor

bind mono_pixel_packer mono_pixel_packer_monitor i_mon (.mclk(mclk), .srst(srst), .frame_start(frame_start),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .byte_data(byte_data), .byte_valid(byte_valid),
    .byte_last(byte_last), .byte_ready(byte_ready), .leader_id(leader_id), .fmt_err(fmt_err));

// file: verification/byte_sink.sv
// Host buffer model: takes bytes off the transport, may stall.
// Assumes it drives ready at the falling edge of mclk.
`timescale 1ns/10ps
module byte_sink (
    input wire logic mclk,
    input wire logic srst,
    input wire logic slow,
    input wire logic [7:0] byte_data,
    input wire logic byte_valid,
    input wire logic byte_last,
    output logic byte_ready
);
    // ======================================================================
    // Ready pattern and capture
    logic [8:0] got[$];
    int cnt;
    // Ready every cycle, or one cycle in four when slow
    initial begin
        byte_ready = 1'b0;
        cnt = 0;
        forever begin
            @(negedge mclk);
            cnt++;
            byte_ready <= !srst && (!slow || cnt % 4 == 0);
        end
    end
    // Keep each accepted byte with its frame end mark
    always @(posedge mclk) begin
        if (!srst && byte_valid && byte_ready) got.push_back({byte_last, byte_data});
    end
endmodule // byte_sink

// file: verification/mono_pixel_packer_tb_top.sv
// Testbench for the mono pixel packer: frames in every layout.
// Assumes the checker is bound and byte_sink stands downstream.
`timescale 1ns/10ps
module mono_pixel_packer_tb_top;
    import mono_pack_pkg::*;
    // ======================================================================
    // Signals and helpers
    logic mclk, srst, frame_start, pix_valid, pix_last, slow;
    logic pix_ready, byte_valid, byte_last, byte_ready, fmt_err;
    pix_fmt_t fmt_sel;
    leader_id_t leader_id;
    logic [PIX_W-1:0] pix_data;
    logic [BYTE_W-1:0] byte_data;
    logic [31:0] seed;
    logic [8:0] exp_q[$];
    int fails, checked;
    mono_pixel_packer i_dut (.mclk(mclk), .srst(srst), .fmt_sel(fmt_sel), .frame_start(frame_start),
        .pix_data(pix_data), .pix_valid(pix_valid), .pix_last(pix_last), .pix_ready(pix_ready),
        .byte_data(byte_data), .byte_valid(byte_valid), .byte_last(byte_last), .byte_ready(byte_ready),
        .leader_id(leader_id), .fmt_err(fmt_err));
    byte_sink i_sink (.mclk(mclk), .srst(srst), .slow(slow), .byte_data(byte_data),
        .byte_valid(byte_valid), .byte_last(byte_last), .byte_ready(byte_ready));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            fails++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Offer one pixel and hold it until taken
    task automatic put(input logic [11:0] d, input logic l);
        int n;
        n = 0;
        pix_data <= d;
        pix_valid <= 1'b1;
        pix_last <= l;
        #1;
        while (pix_ready !== 1'b1 && n < 500) begin
            @(negedge mclk);
            #1;
            n++;
        end
        check(n < 500, "pixel not taken");
        @(negedge mclk);
    endtask
    // One frame: select, send pixels, build expected bytes, compare
    task automatic frame(input pix_fmt_t f, input pix_fmt_t lay, input int n);
        logic [11:0] p, e;
        int k;
        exp_q.delete();
        i_sink.got.delete();
        fmt_sel <= f;
        frame_start <= 1'b1;
        @(negedge mclk);
        frame_start <= 1'b0;
        @(negedge mclk);
        check(fmt_err === (f == FMT_NONE), "format error flag");
        check(leader_id === ((lay == FMT_BYTE8) ? LID_MONO8 : (lay == FMT_WORD16) ? LID_MONO12
            : LID_MONO12_PACKED), "leader id");
        for (k = 0; k < n; k++) begin
            seed = lfsr(seed);
            p = (k == 0) ? 12'hFFF : (k == 1) ? 12'h000 : seed[11:0];
            put(p, k == n - 1);
            if (lay == FMT_BYTE8) exp_q.push_back({k == n - 1, p[11:4]});
            else if (lay == FMT_WORD16) begin
                exp_q.push_back({1'b0, p[7:0]});
                exp_q.push_back({k == n - 1, 4'h0, p[11:8]});
            end else if (k % 2 == 0) begin
                e = p;
                exp_q.push_back({1'b0, p[11:4]});
                if (k == n - 1) begin
                    // Lone final pixel: its nibble under a zero odd nibble, then a zero byte
                    exp_q.push_back({1'b0, 4'h0, p[3:0]});
                    exp_q.push_back({1'b1, 8'h00});
                end
            end else begin
                exp_q.push_back({1'b0, p[3:0], e[3:0]});
                exp_q.push_back({k == n - 1, p[11:4]});
            end
        end
        pix_valid <= 1'b0;
        pix_last <= 1'b0;
        k = 0;
        while (i_sink.got.size() < exp_q.size() && k < 2000) begin
            @(negedge mclk);
            k++;
        end
        check(i_sink.got.size() == exp_q.size(), "byte count");
        for (k = 0; k < exp_q.size() && k < i_sink.got.size(); k++)
            check(i_sink.got[k] === exp_q[k], "byte value");
    endtask
    // Clock of 4 ns
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Watchdog
    initial begin
        #100000;
        fails++;
        report_and_stop();
    end
    // Main sequence: prompt then stalling sink, all layouts
    initial begin
        seed = 32'h78CDD882;
        srst = 1'b1;
        frame_start = 1'b0;
        pix_valid = 1'b0;
        pix_last = 1'b0;
        pix_data = 12'h000;
        fmt_sel = FMT_BYTE8;
        slow = 1'b0;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        srst <= 1'b0;
        @(negedge mclk);
        check(pix_ready === 1'b1 && byte_valid === 1'b0 && leader_id === LID_MONO8, "reset state");
        for (int s = 0; s < 2; s++) begin
            slow <= s[0];
            frame(FMT_BYTE8, FMT_BYTE8, 7 + 13 * s);
            frame(FMT_WORD16, FMT_WORD16, 7 + 13 * s);
            frame(FMT_PACK12, FMT_PACK12, 8 + 11 * s);
            frame(FMT_NONE, FMT_PACK12, 4);
        end
        report_and_stop();
    end
endmodule // mono_pixel_packer_tb_top
